// ### design/nand_host.sv
// Data FIFO and NAND flash host controller
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module nand_wdata_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; empty flag guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module nand_host (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire nand_host_pkg::req_t  req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wdata_valid,
  output logic                      wdata_ready,
  output logic [7:0]                rdata,
  output logic                      rdata_valid,
  output logic                      done,
  output nand_host_pkg::pins_t      pins,
  input  wire logic [7:0]           shared_bus_in,
  input  wire logic                 ready_busy
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_CMD   = 4'h1,
    ST_ADDR  = 4'h3,
    ST_XFER  = 4'h2,
    ST_CMD2  = 4'h6,
    ST_WAITB = 4'h7,
    ST_WAITR = 4'h5,
    ST_DONE  = 4'h4
  } state_t;

  state_t                state_q, state_d;
  nand_host_pkg::req_t   req_q, req_d;
  nand_host_pkg::pins_t  pins_q, pins_d;
  logic [2:0]            phase_q, phase_d;
  logic [9:0]            cnt_q, cnt_d;
  logic [1:0]            aidx_q, aidx_d;
  logic [7:0]            rdata_q, rdata_d;
  logic                  rvalid_q, rvalid_d;
  logic [7:0]            fifo_data;
  logic                  fifo_valid, fifo_pop;
  logic                  strobing, is_read, go, last_phase, req_fire;
  logic [7:0]            byte_sel;

  nand_wdata_fifo #(.WIDTH(nand_host_pkg::DATA_W), .DEPTH(nand_host_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_data   (wdata),
    .in_valid  (wdata_valid),
    .in_ready  (wdata_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign pins        = pins_q;
  assign rdata       = rdata_q;
  assign rdata_valid = rvalid_q;
  assign done        = (state_q == ST_DONE);
  // Only start when the device reports ready
  assign req_ready   = (state_q == ST_IDLE) && ready_busy;
  assign req_fire    = req_valid && req_ready;
  assign is_read     = (req_q.op == nand_host_pkg::OP_READ);
  assign strobing    = (state_q == ST_CMD) || (state_q == ST_ADDR) ||
                       (state_q == ST_XFER) || (state_q == ST_CMD2);
  // Program data stalls the strobe until the FIFO has a byte
  assign go          = (state_q != ST_XFER) || is_read || fifo_valid;
  assign last_phase  = (phase_q == nand_host_pkg::PHASE_LAST);
  assign fifo_pop    = (state_q == ST_XFER) && !is_read && (phase_q == 3'h0) && fifo_valid;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    byte_sel = 8'h00;
    case (state_q)
      ST_CMD: begin
        case (req_q.op)
          nand_host_pkg::OP_READ:
            byte_sel = req_q.half ? nand_host_pkg::CMD_READ_HI
                                  : nand_host_pkg::CMD_READ_LO;
          nand_host_pkg::OP_PROG:  byte_sel = nand_host_pkg::CMD_PROG;
          default:                 byte_sel = nand_host_pkg::CMD_ERASE;
        endcase
      end
      ST_ADDR: begin
        case (aidx_q)
          2'h0:    byte_sel = req_q.col;
          2'h1:    byte_sel = req_q.row[7:0];
          2'h2:    byte_sel = req_q.row[15:8];
          default: byte_sel = {7'h00, req_q.row[16]};
        endcase
      end
      ST_XFER: byte_sel = fifo_data;
      ST_CMD2: byte_sel = (req_q.op == nand_host_pkg::OP_PROG) ?
                          nand_host_pkg::CMD_PROG_GO : nand_host_pkg::CMD_ERASE_GO;
      default: byte_sel = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d  = state_q;
    req_d    = req_q;
    phase_d  = phase_q;
    cnt_d    = cnt_q;
    aidx_d   = aidx_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    pins_d   = pins_q;
    if (strobing && (phase_q != 3'h0 || go)) begin
      phase_d = last_phase ? 3'h0 : phase_q + 3'h1;
    end
    // Byte loaded in setup phase; strobe low for phases 1..last-1
    if (strobing && phase_q == 3'h0 && go) begin
      pins_d.bus_out = byte_sel;
      pins_d.bus_oe  = !(state_q == ST_XFER && is_read);
    end
    pins_d.we_n          = !(strobing && !(state_q == ST_XFER && is_read) &&
                             phase_d != 3'h0 && phase_d != nand_host_pkg::PHASE_LAST);
    pins_d.read_strobe_n = !(state_q == ST_XFER && is_read &&
                             phase_d != 3'h0 && phase_d != nand_host_pkg::PHASE_LAST);
    pins_d.cle = (state_q == ST_CMD) || (state_q == ST_CMD2);
    pins_d.ale = (state_q == ST_ADDR);
    // Read data valid well after the strobe fall; take it on the last low phase
    if (state_q == ST_XFER && is_read && phase_q == nand_host_pkg::PHASE_SAMPLE) begin
      rdata_d  = shared_bus_in;
      rvalid_d = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        pins_d = nand_host_pkg::PINS_IDLE;
        if (req_fire) begin
          req_d       = req;
          state_d     = ST_CMD;
          pins_d.ce_n = 1'b0;
          // Protection released only for program or erase
          pins_d.wp_n = (req.op != nand_host_pkg::OP_READ);
          aidx_d      = (req.op == nand_host_pkg::OP_ERASE) ?
                        nand_host_pkg::ADDR_FIRST_ERASE : nand_host_pkg::ADDR_FIRST_FULL;
        end
      end
      ST_CMD: begin
        if (last_phase) begin
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (last_phase) begin
          aidx_d = aidx_q + 2'h1;
          if (aidx_q == nand_host_pkg::ADDR_LAST) begin
            cnt_d   = '0;
            state_d = (req_q.op == nand_host_pkg::OP_ERASE) ? ST_CMD2 :
                      (req_q.op == nand_host_pkg::OP_PROG) ? ST_XFER : ST_WAITB;
          end
        end
      end
      ST_XFER: begin
        if (last_phase) begin
          cnt_d = cnt_q + 10'h001;
          if (cnt_q + 10'h001 >= req_q.len) begin
            cnt_d   = '0;
            state_d = is_read ? ST_DONE : ST_CMD2;
          end
        end
      end
      ST_CMD2: begin
        if (last_phase) begin
          state_d = ST_WAITB;
        end
      end
      ST_WAITB: begin
        // Busy flag needs time to fall after the last latch
        cnt_d = cnt_q + 10'h001;
        if (cnt_q >= nand_host_pkg::WB_COUNT) begin
          state_d = ST_WAITR;
        end
      end
      ST_WAITR: begin
        cnt_d = '0;
        if (ready_busy) begin
          state_d = (is_read && req_q.len != '0) ? ST_XFER : ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
        pins_d  = nand_host_pkg::PINS_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= ST_IDLE;
      req_q    <= '0;
      pins_q   <= nand_host_pkg::PINS_IDLE;
      phase_q  <= 3'h0;
      cnt_q    <= 10'h000;
      aidx_q   <= 2'h0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      req_q    <= req_d;
      pins_q   <= pins_d;
      phase_q  <= phase_d;
      cnt_q    <= cnt_d;
      aidx_q   <= aidx_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_latch_strobes_exclusive: assert property (@(posedge clk) disable iff (!arst_n)
    !(pins_q.cle && pins_q.ale)) else $error("cle and ale both high");
  chk_write_chip_select: assert property (@(posedge clk) disable iff (!arst_n)
    !pins_q.we_n |-> !pins_q.ce_n) else $error("write strobe without chip select");
  chk_write_pulse_width: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(pins_q.we_n) |=> !pins_q.we_n ##1 pins_q.we_n) else $error("bad write pulse");
  chk_read_high_time: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(pins_q.read_strobe_n) && state_q == ST_XFER |-> pins_q.read_strobe_n[*2])
    else $error("read strobe cycle too short");
  chk_read_bus_released: assert property (@(posedge clk) disable iff (!arst_n)
    !pins_q.read_strobe_n |-> !pins_q.bus_oe) else $error("host drives bus during read");
  chk_read_capture: assert property (@(posedge clk) disable iff (!arst_n)
    rvalid_q |-> !$past(pins_q.read_strobe_n) && !$past(pins_q.read_strobe_n, 2))
    else $error("read data taken outside strobe");
  chk_start_when_ready: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == ST_IDLE && state_d == ST_CMD |-> ready_busy) else $error("start while busy");
  chk_erase_row_only: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == ST_ADDR && req_q.op == nand_host_pkg::OP_ERASE |-> aidx_q != 2'h0)
    else $error("column cycle sent for erase");
  chk_fourth_addr_low: assert property (@(posedge clk) disable iff (!arst_n)
    pins_q.ale && !pins_q.we_n && aidx_q == 2'h3 |-> pins_q.bus_out[7:1] == 7'h00)
    else $error("fourth address cycle spare bits set");
  chk_protect_idle: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> !pins_q.wp_n)
    else $error("write protect released while idle");

  cov_read_done: cover property (@(posedge clk) disable iff (!arst_n)
    done && req_q.op == nand_host_pkg::OP_READ);
  cov_prog_done: cover property (@(posedge clk) disable iff (!arst_n)
    done && req_q.op == nand_host_pkg::OP_PROG);
  cov_erase_done: cover property (@(posedge clk) disable iff (!arst_n)
    done && req_q.op == nand_host_pkg::OP_ERASE);
  cov_fifo_stall: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == ST_XFER && !is_read && !fifo_valid);
endmodule

// ### design/nand_host_pkg.sv
// Shared constants and types for the NAND flash host controller
package nand_host_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int READ_CYCLE_NS = 60;
  localparam int STROBE_CYC    = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_NS         = 100;
  localparam int WB_CYC        = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PHASE_LAST   = 3'(STROBE_CYC);
  localparam logic [2:0] PHASE_SAMPLE = 3'(STROBE_CYC - 1);
  localparam logic [9:0] WB_COUNT     = 10'(WB_CYC);
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W     = 8;
  localparam logic [7:0] CMD_READ_LO = 8'h00;
  localparam logic [7:0] CMD_READ_HI = 8'h01;
  localparam logic [7:0] CMD_PROG    = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE   = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [1:0] ADDR_FIRST_FULL  = 2'h0;
  localparam logic [1:0] ADDR_FIRST_ERASE = 2'h1;
  localparam logic [1:0] ADDR_LAST        = 2'h3;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_PROG  = 2'h1,
    OP_ERASE = 2'h2
  } op_t;

  typedef struct packed {
    op_t         op;
    logic        half;
    logic [7:0]  col;
    logic [16:0] row;
    logic [9:0]  len;
  } req_t;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic       bus_oe;
    logic [7:0] bus_out;
  } pins_t;

  localparam pins_t PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                  read_strobe_n: 1'b1, wp_n: 1'b0, bus_oe: 1'b0,
                                  bus_out: 8'h00};
endpackage

// ### verification/nand_dev_model.sv
// Behavioural model of the NAND flash device at the host's far side
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module nand_dev_model #(
  parameter int PROG_CYC  = 10000,
  parameter int ERASE_CYC = 100000,
  parameter int READ_CYC  = 750
) (
  input  wire logic                 clk,
  input  wire nand_host_pkg::pins_t pins,
  output logic [7:0]                dq_out,
  output logic                      dq_oe,
  output logic                      rb_low,
  output logic [7:0]                err_cnt
);
  logic [7:0] mem [int];
  logic [7:0] ab [4];
  logic [7:0] cmd    = 8'hFF;
  logic [7:0] data_q = 8'h00;
  logic       half   = 1'b0;
  int         na     = 0;
  int         busy   = 0;
  int         key    = 0;
  realtime    t_fall = -100.0;
  initial err_cnt = 8'h00;
  // Released lines show the inverse of the last byte, never a held value
  assign dq_oe  = !pins.ce_n && !pins.read_strobe_n;
  assign dq_out = dq_oe ? data_q : ~data_q;
  // Busy ignores chip select on purpose
  assign rb_low = busy != 0;
  always @(negedge pins.we_n) begin
    if (pins.ce_n) err_cnt++;
  end
  always @(posedge pins.we_n) begin
    if (pins.cle && pins.ale) err_cnt++;
    if (pins.cle) begin
      if (busy != 0 && pins.bus_out != 8'h70 && pins.bus_out != 8'hFF) err_cnt++;
      cmd  = pins.bus_out;
      half = cmd == nand_host_pkg::CMD_READ_HI;
      if (cmd == nand_host_pkg::CMD_PROG_GO || cmd == nand_host_pkg::CMD_ERASE_GO) begin
        if (na != (cmd == nand_host_pkg::CMD_PROG_GO ? 4 : 3)) err_cnt++;
        if (pins.wp_n) busy = cmd == nand_host_pkg::CMD_PROG_GO ? PROG_CYC : ERASE_CYC;
      end else na = 0;
    end else if (pins.ale) begin
      if (na < (cmd == nand_host_pkg::CMD_ERASE ? 3 : 4)) ab[na] = pins.bus_out;
      na++;
      if (na == 4 && cmd != nand_host_pkg::CMD_ERASE) begin
        if (ab[3][7:1] != 7'h00) err_cnt++;
        key = int'({ab[3][0], ab[2], ab[1]}) * 528 + (half ? 256 : 0) + int'(ab[0]);
        if (cmd != nand_host_pkg::CMD_PROG) busy = READ_CYC;
      end
    end else if (cmd == nand_host_pkg::CMD_PROG && pins.wp_n) begin
      mem[key] = pins.bus_out;
      key++;
    end
  end
  always @(negedge pins.read_strobe_n) begin
    if ($realtime - t_fall < 60.0) err_cnt++;
    t_fall = $realtime;
    data_q = mem.exists(key) ? mem[key] : 8'(key ^ (key >> 8));
    key++;
  end
  // Falling edge keeps the busy line from racing the host's sampling edge
  always @(negedge clk) begin
    if (dq_oe && pins.bus_oe) err_cnt++;
    if (busy != 0) busy--;
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the NAND flash host controller
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  localparam int          PROG_CYC  = 300;
  localparam int          ERASE_CYC = 600;
  localparam int          READ_CYC  = 40;
  localparam logic [16:0] ROW       = 17'h1ABCD;
  logic                 clk;
  logic                 arst_n      = 1'b0;
  nand_host_pkg::req_t  req         = '0;
  logic                 req_valid   = 1'b0;
  logic [7:0]           wdata       = 8'h00;
  logic                 wdata_valid = 1'b0;
  logic                 req_ready, wdata_ready, rdata_valid, done, ready_busy, dq_oe, rb_low;
  logic [7:0]           rdata, shared_bus_in, dq_out, err_cnt;
  nand_host_pkg::pins_t pins;
  logic [7:0]           rq [$];
  int                   n_fail      = 0;
  int                   comparisons = 0;
  assign shared_bus_in = pins.bus_oe ? pins.bus_out : dq_out;
  // Pull-up on the open-drain ready line
  assign ready_busy = rb_low ? 1'b0 : 1'b1;
  nand_host i_nand_host (.clk(clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .wdata(wdata), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .rdata(rdata), .rdata_valid(rdata_valid), .done(done),
    .pins(pins), .shared_bus_in(shared_bus_in), .ready_busy(ready_busy));
  nand_dev_model #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .READ_CYC(READ_CYC))
    i_nand_dev_model (.clk(clk), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .rb_low(rb_low), .err_cnt(err_cnt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [7:0] pdat(int i);
    return 8'(i * 13 + 8'h31);
  endfunction
  function automatic logic [7:0] pat(int k);
    return 8'(k ^ (k >> 8));
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Leaves valid high so back-to-back pushes never toggle it in one step
  task automatic push(logic [7:0] b);
    wdata = b;
    wdata_valid = 1'b1;
    for (int k = 0; k < 3000 && wdata_ready !== 1'b1; k++) tick();
    tick();
  endtask
  task automatic run_op(input nand_host_pkg::req_t r, output int cyc);
    rq.delete();
    req = r;
    req_valid = 1'b1;
    for (int k = 0; k < 3000 && req_ready !== 1'b1; k++) tick();
    tick();
    req_valid = 1'b0;
    for (cyc = 0; cyc < 3000; cyc++) begin
      if (rdata_valid === 1'b1) rq.push_back(rdata);
      if (done === 1'b1) break;
      tick();
    end
    check("op done", 32'(done), 32'h1);
  endtask
  task automatic t_reset();
    check("idle pins", 32'(pins), 32'(nand_host_pkg::PINS_IDLE));
    check("ready after reset", 32'(req_ready), 32'h1);
  endtask
  task automatic t_program();
    int cyc;
    for (int i = 0; i < 16; i++) push(pdat(i));
    wdata = pdat(16);
    tick();
    check("full fifo refuses", 32'(wdata_ready), 32'h0);
    fork
      run_op('{nand_host_pkg::OP_PROG, 1'b0, 8'h10, ROW, 10'h014}, cyc);
      begin
        push(pdat(16));
        for (int i = 17; i < 20; i++) begin
          wdata_valid = 1'b0;
          repeat (30) tick();
          push(pdat(i));
        end
        wdata_valid = 1'b0;
      end
    join
    check("program time", 32'(cyc > PROG_CYC && cyc < PROG_CYC + 300), 32'h1);
  endtask
  task automatic t_read_lo();
    int cyc;
    run_op('{nand_host_pkg::OP_READ, 1'b0, 8'h10, ROW, 10'h018}, cyc);
    check("read time", 32'(cyc > READ_CYC), 32'h1);
    check("read count", 32'(rq.size()), 32'h18);
    foreach (rq[i]) begin
      check("read byte", 32'(rq[i]), 32'(i < 20 ? pdat(i) : pat(int'(ROW) * 528 + 16 + i)));
    end
  endtask
  task automatic t_read_hi();
    int cyc;
    run_op('{nand_host_pkg::OP_READ, 1'b1, 8'hFC, ROW, 10'h006}, cyc);
    check("upper count", 32'(rq.size()), 32'h6);
    foreach (rq[i]) check("upper byte", 32'(rq[i]), 32'(pat(int'(ROW) * 528 + 508 + i)));
    run_op('{nand_host_pkg::OP_READ, 1'b0, 8'h00, ROW, 10'h002}, cyc);
    check("lower count", 32'(rq.size()), 32'h2);
    foreach (rq[i]) check("lower byte", 32'(rq[i]), 32'(pat(int'(ROW) * 528 + i)));
  endtask
  task automatic t_erase();
    int cyc;
    fork
      run_op('{nand_host_pkg::OP_ERASE, 1'b0, 8'h00, 17'h00A55, 10'h000}, cyc);
      begin
        repeat (200) tick();
        check("refused while busy", 32'(req_ready), 32'h0);
        check("protect released", 32'(pins.wp_n), 32'h1);
      end
    join
    check("erase time", 32'(cyc > ERASE_CYC && cyc < ERASE_CYC + 60), 32'h1);
    check("protocol faults", 32'(err_cnt), 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_program();
    t_read_lo();
    t_read_hi();
    t_erase();
    end_sim();
  end
  // Whole sequence needs well under 3000 cycles
  initial begin
    #(20 * 20000);
    n_fail++;
    end_sim();
  end
endmodule
